// *** rtl/rf_mac_filter_and_retry.sv ***
// MAC filtering, acknowledged retry, backoff, streaming cap and wake header timing
// Overview of operation
// - Forward payload only on address match; keep listening for sync whenever the channel matches.
// - Accept a packet only when vendor code, channel and address all pass.
// - Check the preamble channel number before the header vendor code.
// - Channel number 0 to 6; peers talk only on equal channel.
// - Match vendor code exactly; all-ones selects the factory code.
// - AND sender destination with mask; must equal own address or mask.
// - Without ack, wait random 0 to slots-1 backoff slots of 38 ms.
// - Slot setting used only with retries or byte cap; zero means no retry backoff, one slot of byte-cap pause.
// - Nonzero retry limit enables acks and retries; zero disables both.
// - Resend packet until ack or sent retry-limit times.
// - Nonzero hold time drops sync info while traffic keeps within it.
// - Zero hold time sends sync info with every packet.
// - After byte cap, pause random 1 to slots+1 slots; zero cap disables.
// - Send wake header after idle time; all-ones means never.
// - Wake header outlasts receiver sleep interval to keep receivers awake.
// - Receiver sleeps after quiet time and timeout; wakes each interval.
`timescale 1ns/1ps
module rf_mac_filter_and_retry #(
    parameter int SLOT_CYC = rf_mac_pkg::SLOT_CYCLES,
    parameter int TICK_CYC = rf_mac_pkg::TICK_CYCLES,
    parameter int WAKE_CYC = 16
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Serial command port
    input wire logic cmd_wr,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] cmd_wdata,
    output logic [15:0] cmd_rdata,
    // Receive header from radio
    input wire logic rx_hdr_valid,
    input wire logic [7:0] rx_hdr_channel,
    input wire logic [15:0] rx_hdr_vendor,
    input wire logic [15:0] rx_hdr_dest,
    output logic rx_forward,
    output logic rx_sync_keep,
    // Transmit request side
    input wire logic tx_pkt_req,
    input wire logic tx_stream_byte,
    input wire logic tx_stream_end,
    input wire logic tx_ack_rcvd,
    input wire logic tx_ack_timeout,
    input wire logic rx_activity,
    input wire logic [15:0] factory_vendor_code,
    output logic tx_pkt_start,
    output logic tx_pkt_done,
    output logic tx_pkt_failed,
    output logic tx_ack_expect,
    output logic tx_with_sync,
    output logic tx_wake_hdr,
    output logic tx_paused
);
    typedef struct packed {
        logic [15:0] target_node_addr;
        logic [15:0] wake_header_quiet_time;
        logic [7:0] hop_channel_num;
        logic [15:0] addr_filter_mask;
        logic [7:0] channel_hold_time;
        logic [7:0] mac_retry_limit;
        logic [7:0] backoff_slot_count;
        logic [15:0] burst_byte_cap;
        logic [15:0] net_vendor_code;
        rf_mac_pkg::tx_state_t tx_state;
        logic [7:0] sends;
        logic [8:0] slots_left;
        logic [31:0] slot_timer;
        logic [31:0] tick_timer;
        logic [15:0] idle_ticks;
        logic [7:0] hold_ticks;
        logic session_open;
        logic [15:0] burst_bytes;
        logic [15:0] lfsr;
        logic [31:0] wake_timer;
        logic pkt_start;
        logic pkt_done;
        logic pkt_failed;
        logic with_sync;
        logic wake_hdr;
        logic [15:0] rdata;
    } mac_state_t;
    mac_state_t st, next_st;

    function automatic logic [8:0] draw_slots(input logic [15:0] rnd, input logic [7:0] n,
                                              input logic plus_one);
        logic [8:0] r;
        r = '0;
        if (n != 8'h00) begin
            r = 9'((rnd % {8'h00, n}) );
        end
        if (plus_one) begin
            r = 9'((rnd % ({8'h00, n} + 16'h0001)) + 16'h0001);
        end
        return r;
    endfunction : draw_slots

    rx_filter_if fif ();
    rx_packet_filter u_filter (
        .core_clk(core_clk),
        .rst(rst),
        .fif(fif)
    );

    logic [15:0] eff_vendor;
    logic retry_on, activity, tick, cap_hit;

    always_comb begin
        eff_vendor = (st.net_vendor_code == rf_mac_pkg::VENDOR_ALL_ONES) ?
            factory_vendor_code : st.net_vendor_code;
        fif.hdr_valid = rx_hdr_valid;
        fif.hdr_channel = rx_hdr_channel;
        fif.hdr_vendor = rx_hdr_vendor;
        fif.hdr_dest = rx_hdr_dest;
        fif.own_channel = st.hop_channel_num;
        fif.own_vendor = eff_vendor;
        fif.own_addr = st.target_node_addr;
        fif.own_mask = st.addr_filter_mask;
        retry_on = (st.mac_retry_limit != 8'h00);
        activity = tx_pkt_req || tx_stream_byte || rx_activity;
        tick = (st.tick_timer >= 32'(TICK_CYC - 1));
        cap_hit = (st.burst_byte_cap != 16'h0000) && tx_stream_byte &&
            (st.burst_bytes + 16'h0001 >= st.burst_byte_cap);
    end

    always_comb begin
        next_st = st;
        next_st.pkt_start = 1'b0;
        next_st.pkt_done = 1'b0;
        next_st.pkt_failed = 1'b0;
        next_st.lfsr = {st.lfsr[14:0], st.lfsr[15] ^ st.lfsr[13] ^ st.lfsr[12] ^ st.lfsr[10]};
        // Command register writes
        if (cmd_wr) begin
            unique case (cmd_code)
                rf_mac_pkg::OFF_TARGET_NODE_ADDR: next_st.target_node_addr = cmd_wdata;
                rf_mac_pkg::OFF_WAKE_HEADER_QUIET_TIME: next_st.wake_header_quiet_time = cmd_wdata;
                rf_mac_pkg::OFF_HOP_CHANNEL_NUM: begin
                    if (cmd_wdata[7:0] <= rf_mac_pkg::HOP_CHANNEL_MAX) begin
                        next_st.hop_channel_num = cmd_wdata[7:0];
                    end
                end
                rf_mac_pkg::OFF_ADDR_FILTER_MASK: next_st.addr_filter_mask = cmd_wdata;
                rf_mac_pkg::OFF_CHANNEL_HOLD_TIME: next_st.channel_hold_time = cmd_wdata[7:0];
                rf_mac_pkg::OFF_MAC_RETRY_LIMIT: next_st.mac_retry_limit = cmd_wdata[7:0];
                rf_mac_pkg::OFF_BACKOFF_SLOT_COUNT: next_st.backoff_slot_count = cmd_wdata[7:0];
                rf_mac_pkg::OFF_BURST_BYTE_CAP: next_st.burst_byte_cap = cmd_wdata;
                rf_mac_pkg::OFF_NET_VENDOR_CODE: next_st.net_vendor_code = cmd_wdata;
                default: ;
            endcase
        end
        // Read data, registered
        unique case (cmd_code)
            rf_mac_pkg::OFF_TARGET_NODE_ADDR: next_st.rdata = st.target_node_addr;
            rf_mac_pkg::OFF_WAKE_HEADER_QUIET_TIME: next_st.rdata = st.wake_header_quiet_time;
            rf_mac_pkg::OFF_HOP_CHANNEL_NUM: next_st.rdata = {8'h00, st.hop_channel_num};
            rf_mac_pkg::OFF_ADDR_FILTER_MASK: next_st.rdata = st.addr_filter_mask;
            rf_mac_pkg::OFF_CHANNEL_HOLD_TIME: next_st.rdata = {8'h00, st.channel_hold_time};
            rf_mac_pkg::OFF_MAC_RETRY_LIMIT: next_st.rdata = {8'h00, st.mac_retry_limit};
            rf_mac_pkg::OFF_BACKOFF_SLOT_COUNT: next_st.rdata = {8'h00, st.backoff_slot_count};
            rf_mac_pkg::OFF_BURST_BYTE_CAP: next_st.rdata = st.burst_byte_cap;
            rf_mac_pkg::OFF_NET_VENDOR_CODE: next_st.rdata = st.net_vendor_code;
            default: next_st.rdata = 16'h0000;
        endcase
        // 100 ms tick, idle and hold timers
        next_st.tick_timer = tick ? 32'h0000_0000 : st.tick_timer + 32'h0000_0001;
        if (activity) begin
            next_st.idle_ticks = 16'h0000;
            next_st.hold_ticks = 8'h00;
        end else if (tick) begin
            if (st.idle_ticks != 16'hffff) next_st.idle_ticks = st.idle_ticks + 16'h0001;
            if (st.hold_ticks != 8'hff) next_st.hold_ticks = st.hold_ticks + 8'h01;
        end
        if (st.channel_hold_time == 8'h00 || st.hold_ticks > st.channel_hold_time) begin
            next_st.session_open = 1'b0;
        end
        // Streaming byte counter
        if (tx_stream_end) begin
            next_st.burst_bytes = 16'h0000;
        end else if (tx_stream_byte && st.tx_state != rf_mac_pkg::TX_BACKOFF) begin
            next_st.burst_bytes = st.burst_bytes + 16'h0001;
        end
        unique case (st.tx_state)
            rf_mac_pkg::TX_IDLE: begin
                if (cap_hit) begin
                    next_st.slots_left = draw_slots(st.lfsr, st.backoff_slot_count, 1'b1);
                    next_st.slot_timer = 32'h0000_0000;
                    next_st.burst_bytes = 16'h0000;
                    // Stale retry count would turn the pause into a resend
                    next_st.sends = 8'h00;
                    next_st.tx_state = rf_mac_pkg::TX_BACKOFF;
                end else if (tx_pkt_req) begin
                    if (st.wake_header_quiet_time != rf_mac_pkg::WAKE_NEVER &&
                        st.idle_ticks >= st.wake_header_quiet_time) begin
                        next_st.wake_hdr = 1'b1;
                        next_st.wake_timer = 32'h0000_0000;
                        next_st.tx_state = rf_mac_pkg::TX_WAKE;
                    end else begin
                        next_st.tx_state = rf_mac_pkg::TX_SEND;
                    end
                    next_st.sends = 8'h00;
                end
            end
            rf_mac_pkg::TX_WAKE: begin
                next_st.wake_timer = st.wake_timer + 32'h0000_0001;
                if (st.wake_timer >= 32'(WAKE_CYC - 1)) begin
                    next_st.wake_hdr = 1'b0;
                    next_st.tx_state = rf_mac_pkg::TX_SEND;
                end
            end
            rf_mac_pkg::TX_SEND: begin
                next_st.pkt_start = 1'b1;
                next_st.with_sync = !st.session_open;
                next_st.session_open = (st.channel_hold_time != 8'h00);
                next_st.sends = st.sends + 8'h01;
                if (retry_on) begin
                    next_st.tx_state = rf_mac_pkg::TX_WAIT_ACK;
                end else begin
                    next_st.pkt_done = 1'b1;
                    next_st.tx_state = rf_mac_pkg::TX_IDLE;
                end
            end
            rf_mac_pkg::TX_WAIT_ACK: begin
                if (tx_ack_rcvd) begin
                    next_st.pkt_done = 1'b1;
                    next_st.tx_state = rf_mac_pkg::TX_IDLE;
                end else if (tx_ack_timeout) begin
                    if (st.sends >= st.mac_retry_limit) begin
                        next_st.pkt_failed = 1'b1;
                        next_st.tx_state = rf_mac_pkg::TX_IDLE;
                    end else begin
                        next_st.slots_left = draw_slots(st.lfsr, st.backoff_slot_count,
                            1'b0);
                        next_st.slot_timer = 32'h0000_0000;
                        next_st.tx_state = rf_mac_pkg::TX_BACKOFF;
                    end
                end
            end
            rf_mac_pkg::TX_BACKOFF: begin
                if (st.slots_left == 9'h000) begin
                    // Back to send if a retry was pending, else stream resumes
                    next_st.tx_state = (st.sends != 8'h00 && retry_on) ?
                        rf_mac_pkg::TX_SEND : rf_mac_pkg::TX_IDLE;
                    if (st.sends == 8'h00 || !retry_on) next_st.sends = 8'h00;
                end else if (st.slot_timer >= 32'(SLOT_CYC - 1)) begin
                    next_st.slot_timer = 32'h0000_0000;
                    next_st.slots_left = st.slots_left - 9'h001;
                end else begin
                    next_st.slot_timer = st.slot_timer + 32'h0000_0001;
                end
            end
            default: next_st.tx_state = rf_mac_pkg::TX_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
            st.target_node_addr <= rf_mac_pkg::RST_TARGET_NODE_ADDR;
            st.wake_header_quiet_time <= rf_mac_pkg::RST_WAKE_HEADER_QUIET_TIME;
            st.hop_channel_num <= rf_mac_pkg::RST_HOP_CHANNEL_NUM;
            st.addr_filter_mask <= rf_mac_pkg::RST_ADDR_FILTER_MASK;
            st.channel_hold_time <= rf_mac_pkg::RST_CHANNEL_HOLD_TIME;
            st.mac_retry_limit <= rf_mac_pkg::RST_MAC_RETRY_LIMIT;
            st.backoff_slot_count <= rf_mac_pkg::RST_BACKOFF_SLOT_COUNT;
            st.burst_byte_cap <= rf_mac_pkg::RST_BURST_BYTE_CAP;
            st.net_vendor_code <= rf_mac_pkg::RST_NET_VENDOR_CODE;
            st.lfsr <= rf_mac_pkg::LFSR_SEED;
        end else begin
            st <= next_st;
        end
    end

    assign cmd_rdata = st.rdata;
    assign rx_forward = fif.verdict_accept;
    assign rx_sync_keep = fif.verdict_chan_ok;
    assign tx_pkt_start = st.pkt_start;
    assign tx_pkt_done = st.pkt_done;
    assign tx_pkt_failed = st.pkt_failed;
    assign tx_ack_expect = (st.tx_state == rf_mac_pkg::TX_WAIT_ACK);
    assign tx_with_sync = st.with_sync;
    assign tx_wake_hdr = st.wake_hdr;
    assign tx_paused = (st.tx_state == rf_mac_pkg::TX_BACKOFF);

    a_no_ack_off: assert property (@(posedge core_clk) disable iff (rst)
        (st.mac_retry_limit == 8'h00) |-> !tx_ack_expect)
        else $error("ack awaited with retries off");
    a_send_limit: assert property (@(posedge core_clk) disable iff (rst)
        tx_pkt_start |-> st.sends <= st.mac_retry_limit || st.mac_retry_limit == 8'h00)
        else $error("sent more than retry limit");
    a_sync_zero_hold: assert property (@(posedge core_clk) disable iff (rst)
        (tx_pkt_start && st.channel_hold_time == 8'h00) |-> tx_with_sync)
        else $error("sync missing with zero hold");
    a_retry_range: assert property (@(posedge core_clk) disable iff (rst)
        ($rose(tx_paused) && st.sends != 8'h00) |->
        (st.slots_left < {1'b0, st.backoff_slot_count} || st.slots_left == 9'h000))
        else $error("retry backoff out of range");
    a_cap_range: assert property (@(posedge core_clk) disable iff (rst)
        ($rose(tx_paused) && st.sends == 8'h00) |->
        (st.slots_left >= 9'h001 && st.slots_left <= {1'b0, st.backoff_slot_count} + 9'h001))
        else $error("cap pause out of range");
    a_cap_clears: assert property (@(posedge core_clk) disable iff (rst)
        $rose(tx_paused) && st.sends == 8'h00 |-> st.burst_bytes == 16'h0000)
        else $error("byte counter not cleared");
    a_chan_legal: assert property (@(posedge core_clk) disable iff (rst)
        st.hop_channel_num <= rf_mac_pkg::HOP_CHANNEL_MAX)
        else $error("channel out of range");
    a_wake_never: assert property (@(posedge core_clk) disable iff (rst)
        (st.wake_header_quiet_time == rf_mac_pkg::WAKE_NEVER && st.tx_state ==
        rf_mac_pkg::TX_IDLE) |=> !$rose(tx_wake_hdr))
        else $error("wake header sent when disabled");
    c_forward: cover property (@(posedge core_clk) disable iff (rst) rx_forward);
    c_retry: cover property (@(posedge core_clk) disable iff (rst) tx_pkt_start && st.sends > 8'h01);
    c_pause: cover property (@(posedge core_clk) disable iff (rst) $rose(tx_paused));
    c_wake: cover property (@(posedge core_clk) disable iff (rst) $rose(tx_wake_hdr));
endmodule : rf_mac_filter_and_retry

// *** rtl/rf_mac_pkg.sv ***
// Package with register map, reset values and timing constants of the MAC filter block
package rf_mac_pkg;
    // Register offsets (binary command codes)
    localparam logic [7:0] OFF_TARGET_NODE_ADDR = 8'h00;
    localparam logic [7:0] OFF_WAKE_HEADER_QUIET_TIME = 8'h03;
    localparam logic [7:0] OFF_HOP_CHANNEL_NUM = 8'h11;
    localparam logic [7:0] OFF_ADDR_FILTER_MASK = 8'h12;
    localparam logic [7:0] OFF_CHANNEL_HOLD_TIME = 8'h17;
    localparam logic [7:0] OFF_MAC_RETRY_LIMIT = 8'h18;
    localparam logic [7:0] OFF_BACKOFF_SLOT_COUNT = 8'h19;
    localparam logic [7:0] OFF_BURST_BYTE_CAP = 8'h1a;
    localparam logic [7:0] OFF_NET_VENDOR_CODE = 8'h27;
    // Reset values
    localparam logic [15:0] RST_TARGET_NODE_ADDR = 16'h0000;
    localparam logic [15:0] RST_WAKE_HEADER_QUIET_TIME = 16'hffff;
    localparam logic [7:0] RST_HOP_CHANNEL_NUM = 8'h00;
    localparam logic [15:0] RST_ADDR_FILTER_MASK = 16'hffff;
    localparam logic [7:0] RST_CHANNEL_HOLD_TIME = 8'h00;
    localparam logic [7:0] RST_MAC_RETRY_LIMIT = 8'h00;
    localparam logic [7:0] RST_BACKOFF_SLOT_COUNT = 8'h00;
    localparam logic [15:0] RST_BURST_BYTE_CAP = 16'hffff;
    // Arbitrary neutral value, not any real factory code
    localparam logic [15:0] RST_NET_VENDOR_CODE = 16'h8a5c;
    localparam logic [15:0] VENDOR_ALL_ONES = 16'hffff;
    localparam logic [15:0] VENDOR_FACTORY_BASE = 16'h8000;
    localparam logic [7:0] HOP_CHANNEL_MAX = 8'h06;
    localparam logic [15:0] WAKE_NEVER = 16'hffff;
    localparam logic [15:0] LFSR_SEED = 16'hace1;
    // Timing
    localparam int CLK_PERIOD_PS = 5000;
    localparam int SLOT_TIME_MS = 38;
    localparam int TICK_TIME_MS = 100;
    localparam int SLOT_CYCLES = SLOT_TIME_MS * (1000000000 / CLK_PERIOD_PS);
    localparam int TICK_CYCLES = TICK_TIME_MS * (1000000000 / CLK_PERIOD_PS);
    // Transmit sequencer states
    typedef enum logic [2:0] {
        TX_IDLE = 3'b000,
        TX_SEND = 3'b001,
        TX_WAIT_ACK = 3'b010,
        TX_BACKOFF = 3'b011,
        TX_WAKE = 3'b100
    } tx_state_t;
endpackage : rf_mac_pkg

// *** rtl/rx_filter_if.sv ***
// Interface carrying a received header to the filter and its verdict back
`timescale 1ns/1ps
interface rx_filter_if;
    logic hdr_valid;
    logic [7:0] hdr_channel;
    logic [15:0] hdr_vendor;
    logic [15:0] hdr_dest;
    logic [7:0] own_channel;
    logic [15:0] own_vendor;
    logic [15:0] own_addr;
    logic [15:0] own_mask;
    logic verdict_valid;
    logic verdict_accept;
    logic verdict_chan_ok;
    modport filter (input hdr_valid, hdr_channel, hdr_vendor, hdr_dest, own_channel,
        own_vendor, own_addr, own_mask, output verdict_valid, verdict_accept, verdict_chan_ok);
    modport owner (output hdr_valid, hdr_channel, hdr_vendor, hdr_dest, own_channel,
        own_vendor, own_addr, own_mask, input verdict_valid, verdict_accept, verdict_chan_ok);
endinterface : rx_filter_if

// *** rtl/rx_packet_filter.sv ***
// Receive filter: channel, then vendor code, then masked destination address
`timescale 1ns/1ps
module rx_packet_filter (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Header and verdict
    rx_filter_if.filter fif
);
    typedef struct packed {
        logic verdict_valid;
        logic verdict_accept;
        logic verdict_chan_ok;
    } filt_state_t;
    filt_state_t st, next_st;
    logic chan_ok, vend_ok, addr_ok;
    logic [15:0] masked;

    always_comb begin
        masked = fif.hdr_dest & fif.own_mask;
        chan_ok = (fif.hdr_channel == fif.own_channel);
        vend_ok = (fif.hdr_vendor == fif.own_vendor);
        addr_ok = (masked == fif.own_addr) || (masked == fif.own_mask);
        next_st.verdict_valid = fif.hdr_valid;
        next_st.verdict_chan_ok = fif.hdr_valid && chan_ok;
        next_st.verdict_accept = fif.hdr_valid && chan_ok && vend_ok && addr_ok;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign fif.verdict_valid = st.verdict_valid;
    assign fif.verdict_accept = st.verdict_accept;
    assign fif.verdict_chan_ok = st.verdict_chan_ok;

    a_accept_all_three: assert property (@(posedge core_clk) disable iff (rst)
        fif.verdict_accept |-> $past(chan_ok && vend_ok && addr_ok && fif.hdr_valid))
        else $error("accepted packet failed a filter");
    a_chan_first: assert property (@(posedge core_clk) disable iff (rst)
        fif.verdict_accept |-> fif.verdict_chan_ok)
        else $error("accepted without channel match");
    a_mask_reject: assert property (@(posedge core_clk) disable iff (rst)
        (fif.hdr_valid && !addr_ok) |=> !fif.verdict_accept)
        else $error("address mismatch accepted");
endmodule : rx_packet_filter

// *** testbench/peer_radio.sv ***
// Peer radio model answering or ignoring each acknowledged send
`timescale 1ns/1ps
module peer_radio (
    // Clock and bench control
    input wire logic core_clk,
    input wire logic ack_on,
    // Device side
    input wire logic tx_ack_expect,
    output logic tx_ack_rcvd,
    output logic tx_ack_timeout
);
    initial begin
        tx_ack_rcvd = 1'b0;
        tx_ack_timeout = 1'b0;
        forever begin
            @(posedge core_clk);
            #1;
            if (tx_ack_expect === 1'b1) begin
                repeat (3) @(posedge core_clk);
                #1;
                tx_ack_rcvd = ack_on;
                tx_ack_timeout = !ack_on;
                @(posedge core_clk);
                #1;
                tx_ack_rcvd = 1'b0;
                tx_ack_timeout = 1'b0;
            end
        end
    end
endmodule : peer_radio

// *** testbench/testbench.sv ***
// Self-checking bench for the MAC filter and retry block
`timescale 1ns/1ps
module testbench;
    logic core_clk, rst, cmd_wr, rx_hdr_valid, rx_forward, rx_sync_keep, tx_pkt_req;
    logic tx_stream_byte, tx_stream_end, tx_ack_rcvd, tx_ack_timeout, rx_activity;
    logic tx_pkt_start, tx_pkt_done, tx_pkt_failed, tx_ack_expect, tx_with_sync;
    logic tx_wake_hdr, tx_paused, ack_on;
    logic [7:0] cmd_code, rx_hdr_channel;
    logic [15:0] cmd_wdata, cmd_rdata, rx_hdr_vendor, rx_hdr_dest, factory_vendor_code;
    int n_mismatch = 0;
    int total_checks = 0;
    int wake_cyc = 0;
    logic [7:0] codes [9] = '{8'h00, 8'h03, 8'h11, 8'h12, 8'h17, 8'h18, 8'h19, 8'h1a, 8'h27};
    logic [15:0] resets [9] = '{16'h0000, 16'hffff, 16'h0000, 16'hffff, 16'h0000, 16'h0000,
        16'h0000, 16'hffff, rf_mac_pkg::RST_NET_VENDOR_CODE};

    rf_mac_filter_and_retry #(.SLOT_CYC(4), .TICK_CYC(8)) dut_u (.core_clk(core_clk),
        .rst(rst), .cmd_wr(cmd_wr), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
        .cmd_rdata(cmd_rdata), .rx_hdr_valid(rx_hdr_valid), .rx_hdr_channel(rx_hdr_channel),
        .rx_hdr_vendor(rx_hdr_vendor), .rx_hdr_dest(rx_hdr_dest), .rx_forward(rx_forward),
        .rx_sync_keep(rx_sync_keep), .tx_pkt_req(tx_pkt_req), .tx_stream_byte(tx_stream_byte),
        .tx_stream_end(tx_stream_end), .tx_ack_rcvd(tx_ack_rcvd),
        .tx_ack_timeout(tx_ack_timeout), .rx_activity(rx_activity),
        .factory_vendor_code(factory_vendor_code), .tx_pkt_start(tx_pkt_start),
        .tx_pkt_done(tx_pkt_done), .tx_pkt_failed(tx_pkt_failed),
        .tx_ack_expect(tx_ack_expect), .tx_with_sync(tx_with_sync),
        .tx_wake_hdr(tx_wake_hdr), .tx_paused(tx_paused));
    peer_radio peer_u (.core_clk(core_clk), .ack_on(ack_on), .tx_ack_expect(tx_ack_expect),
        .tx_ack_rcvd(tx_ack_rcvd), .tx_ack_timeout(tx_ack_timeout));

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) if (tx_wake_hdr === 1'b1) wake_cyc <= wake_cyc + 1;

    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : step
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        cmd_code = c;
        cmd_wdata = d;
        cmd_wr = 1'b1;
        step(1);
        cmd_wr = 1'b0;
        step(1);
    endtask : wr
    task automatic rd(input logic [7:0] c, input logic [15:0] exp);
        cmd_code = c;
        step(2);
        chk("register", exp, cmd_rdata);
    endtask : rd
    task automatic hdr(input logic [7:0] ch, input logic [15:0] v, input logic [15:0] d,
        input logic fwd, input logic keep);
        logic f;
        logic k;
        f = 1'b0;
        k = 1'b0;
        rx_hdr_channel = ch;
        rx_hdr_vendor = v;
        rx_hdr_dest = d;
        rx_hdr_valid = 1'b1;
        step(1);
        rx_hdr_valid = 1'b0;
        repeat (3) begin
            f = f | rx_forward;
            k = k | rx_sync_keep;
            step(1);
        end
        chk("forward", {15'h0, fwd}, {15'h0, f});
        chk("sync_keep", {15'h0, keep}, {15'h0, k});
    endtask : hdr
    task automatic send(input logic [15:0] n_exp, input logic fail, input logic sync);
        logic [15:0] starts;
        logic fin;
        logic failed;
        logic s;
        starts = 16'h0;
        fin = 1'b0;
        failed = 1'b0;
        s = 1'b0;
        tx_pkt_req = 1'b1;
        step(1);
        tx_pkt_req = 1'b0;
        for (int i = 0; i < 400 && !fin; i++) begin
            if (tx_pkt_start === 1'b1) begin
                starts++;
                s = tx_with_sync;
            end
            if (tx_pkt_done === 1'b1 || tx_pkt_failed === 1'b1) begin
                fin = 1'b1;
                failed = tx_pkt_failed;
            end
            if (!fin) step(1);
        end
        if (!fin) begin
            n_mismatch++;
            wrap_up();
        end
        chk("starts", n_exp, starts);
        chk("failed", {15'h0, fail}, {15'h0, failed});
        chk("with_sync", {15'h0, sync}, {15'h0, s});
        step(2);
    endtask : send
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : wrap_up

    initial begin
        rst = 1'b1;
        {cmd_wr, rx_hdr_valid, tx_pkt_req, tx_stream_byte, tx_stream_end} = 5'h0;
        {rx_activity, ack_on} = 2'h0;
        {cmd_code, rx_hdr_channel} = 16'h0;
        {cmd_wdata, rx_hdr_vendor, rx_hdr_dest} = 48'h0;
        factory_vendor_code = 16'h4321;
        step(8);
        rst = 1'b0;
        foreach (codes[i]) rd(codes[i], resets[i]);
        rd(8'h05, 16'h0000);
        wr(8'h11, 16'h0006);
        rd(8'h11, 16'h0006);
        wr(8'h11, 16'h0007);
        rd(8'h11, 16'h0006);
        $display("test registers done");
        wr(8'h11, 16'h0003);
        wr(8'h27, 16'h1234);
        wr(8'h00, 16'h0012);
        wr(8'h12, 16'h00ff);
        hdr(8'h03, 16'h1234, 16'h0012, 1'b1, 1'b1);
        hdr(8'h03, 16'h1234, 16'hab12, 1'b1, 1'b1);
        hdr(8'h03, 16'h1234, 16'h00ff, 1'b1, 1'b1);
        hdr(8'h03, 16'h1234, 16'h0013, 1'b0, 1'b1);
        hdr(8'h02, 16'h1234, 16'h0012, 1'b0, 1'b0);
        hdr(8'h03, 16'h1235, 16'h0012, 1'b0, 1'b1);
        wr(8'h27, 16'hffff);
        hdr(8'h03, 16'h4321, 16'h0012, 1'b1, 1'b1);
        $display("test filter done");
        send(16'h1, 1'b0, 1'b1);
        wr(8'h18, 16'h0002);
        send(16'h2, 1'b1, 1'b1);
        wr(8'h19, 16'h0003);
        send(16'h2, 1'b1, 1'b1);
        ack_on = 1'b1;
        send(16'h1, 1'b0, 1'b1);
        wr(8'h18, 16'h0000);
        wr(8'h17, 16'h0001);
        send(16'h1, 1'b0, 1'b1);
        send(16'h1, 1'b0, 1'b0);
        rx_activity = 1'b1;
        step(40);
        rx_activity = 1'b0;
        send(16'h1, 1'b0, 1'b0);
        step(40);
        send(16'h1, 1'b0, 1'b1);
        $display("test transmit done");
        wr(8'h1a, 16'h0002);
        repeat (2) begin
            tx_stream_byte = 1'b1;
            step(1);
            tx_stream_byte = 1'b0;
            step(1);
        end
        for (int i = 0; i < 20 && tx_paused !== 1'b1; i++) step(1);
        chk("paused", 16'h1, {15'h0, tx_paused});
        tx_stream_end = 1'b1;
        step(1);
        tx_stream_end = 1'b0;
        step(40);
        chk("wake_cycles", 16'h0000, 16'(wake_cyc));
        $display("test stream done");
        wr(8'h03, 16'h0001);
        step(20);
        send(16'h1, 1'b0, 1'b1);
        chk("wake_cycles", 16'h0010, 16'(wake_cyc));
        $display("test wake done");
        wrap_up();
    end
endmodule : testbench
